// ==== rtl/door_lantern_alarm_supervisor.v ====
/*
 * car-level supervisor: door reversal interlock, fire recall reclose,
 * lanterns and gongs, relay coil redundancy monitor, alarm bell warnings,
 * and an avalon-mm register slave with a masked level interrupt.
 * assumes all inputs are synchronous to ref_clk_i and already debounced.
 */
// Chosen here: register access over Avalon-MM and the placing of the registers.
`timescale 1ns/1ps
`include "door_lantern_alarm_supervisor_defines.vh"
`default_nettype none

module door_lantern_alarm_supervisor #(
	parameter MS_CYCLES = `MS_NS / `CLK_PERIOD_NS
) (
	input  wire        ref_clk_i,
	input  wire        rst_n_i,
	input  wire [5:0]  avs_address_i,
	input  wire        avs_read_i,
	input  wire        avs_write_i,
	input  wire [31:0] avs_writedata_i,
	output reg  [31:0] avs_readdata_o,
	output wire        avs_waitrequest_o,
	output wire        irq_o,
	input  wire        door_open_cmd_i,
	input  wire        door_close_cmd_i,
	output wire        door_open_o,
	output wire        door_close_o,
	input  wire        fire_recall_i,
	input  wire        car_door_open_btn_i,
	input  wire        hall_door_open_btn_i,
	input  wire        car_slowing_i,
	input  wire        door_lock_open_i,
	input  wire        dir_down_i,
	input  wire        passing_floor_i,
	input  wire        passing_chime_enable_input_i,
	input  wire [7:0]  floor_i,
	input  wire        door_opening_i,
	input  wire        door_closing_i,
	input  wire        door_full_open_i,
	input  wire        door_full_closed_i,
	input  wire        monitored_relay_coil_i,
	input  wire        relay_coil_readback_i,
	input  wire        auxiliary_fault_reset_i,
	input  wire        alarm_bell_input_i,
	input  wire        alarm_reset_ack_i,
	input  wire        car_moving_i,
	input  wire        door_zone_i,
	input  wire        idle_movement_check_i,
	output reg         idle_check_req_o,
	output reg         lantern_o,
	output reg         gong_o,
	output reg         passing_floor_chime_o,
	output reg         egress_arrival_chime_o,
	output reg         car_lantern_o,
	output reg         shutdown_o,
	output reg         monitor_alert_o,
	output reg         alarm_indicator_o
);

	// ********************************
	// millisecond and second ticks
	// ********************************
	reg [15:0] ms_cnt_q;
	reg        ms_tick_q;
	reg [9:0]  sec_cnt_q;
	wire       sec_tick = ms_tick_q && (sec_cnt_q == `MS_PER_S - 10'h001);

	always @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			ms_cnt_q  <= 16'h0000;
			ms_tick_q <= 1'b0;
			sec_cnt_q <= 10'h000;
		end else begin
			ms_tick_q <= (ms_cnt_q == MS_CYCLES[15:0] - 16'h0001);
			if (ms_cnt_q == MS_CYCLES[15:0] - 16'h0001)
				ms_cnt_q <= 16'h0000;
			else
				ms_cnt_q <= ms_cnt_q + 16'h0001;
			if (sec_tick)
				sec_cnt_q <= 10'h000;
			else if (ms_tick_q)
				sec_cnt_q <= sec_cnt_q + 10'h001;
		end
	end

	// ********************************
	// register bus
	// ********************************
	reg [`CTRL_W-1:0] ctrl_q;
	reg [14:0]        timing_q;
	reg [8:0]         egress_q;
	reg [`INT_W-1:0]  int_stat_q;
	reg [`INT_W-1:0]  int_mask_q;
	reg               ack_q;
	wire [`INT_W-1:0] ev;
	wire              access = avs_read_i | avs_write_i;
	wire              wr_en = avs_write_i & ack_q;
	wire [1:0]        door_dir;

	// one wait state on every access keeps read data registered
	assign avs_waitrequest_o = access & ~ack_q;
	assign irq_o = |(int_stat_q & int_mask_q);

	always @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			ack_q          <= 1'b0;
			avs_readdata_o <= 32'h00000000;
			ctrl_q         <= `CTRL_RST;
			timing_q       <= 15'h0000;
			egress_q       <= 9'h000;
			int_stat_q     <= {`INT_W{1'b0}};
			int_mask_q     <= {`INT_W{1'b0}};
		end else begin
			ack_q <= access & ~ack_q;
			if (access && !ack_q) begin
				case (avs_address_i)
				`OFF_CTRL:     avs_readdata_o <= {26'h0000000, ctrl_q};
				`OFF_TIMING:   avs_readdata_o <= {17'h00000, timing_q};
				`OFF_EGRESS:   avs_readdata_o <= {23'h000000, egress_q};
				`OFF_STATE:    avs_readdata_o <= {22'h000000, door_dir, idle_check_req_o,
					car_lantern_o, alarm_indicator_o, monitor_alert_o, shutdown_o,
					egress_arrival_chime_o, passing_floor_chime_o, lantern_o};
				`OFF_INT_STAT: avs_readdata_o <= {28'h0000000, int_stat_q};
				`OFF_INT_MASK: avs_readdata_o <= {28'h0000000, int_mask_q};
				default:       avs_readdata_o <= 32'h00000000;
				endcase
			end
			if (wr_en && avs_address_i == `OFF_CTRL)
				ctrl_q <= avs_writedata_i[`CTRL_W-1:0];
			if (wr_en && avs_address_i == `OFF_TIMING)
				timing_q <= avs_writedata_i[14:0];
			if (wr_en && avs_address_i == `OFF_EGRESS)
				egress_q <= avs_writedata_i[8:0];
			if (wr_en && avs_address_i == `OFF_INT_MASK)
				int_mask_q <= avs_writedata_i[`INT_W-1:0];
			// new events win over a write-one clear
			if (wr_en && avs_address_i == `OFF_INT_STAT)
				int_stat_q <= (int_stat_q & ~avs_writedata_i[`INT_W-1:0]) | ev;
			else
				int_stat_q <= int_stat_q | ev;
		end
	end

	// ********************************
	// fire recall reclose
	// ********************************
	wire [6:0] recl_s = timing_q[`TIM_RECL_MSB:`TIM_RECL_LSB];
	wire       open_btn = car_door_open_btn_i | hall_door_open_btn_i;
	reg  [6:0] recl_cnt_q;
	reg        fire_close_q;

	always @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			recl_cnt_q   <= 7'h00;
			fire_close_q <= 1'b0;
		end else if (!fire_recall_i || recl_s == 7'h00) begin
			recl_cnt_q   <= 7'h00;
			fire_close_q <= 1'b0;
		end else if (open_btn) begin
			recl_cnt_q   <= 7'h00;
			fire_close_q <= 1'b0;
		end else if (sec_tick && !fire_close_q) begin
			if (recl_cnt_q + 7'h01 >= recl_s)
				fire_close_q <= 1'b1;
			recl_cnt_q <= recl_cnt_q + 7'h01;
		end
	end

	// ********************************
	// door reversal interlock
	// ********************************
	wire       eff_open = door_open_cmd_i | (fire_recall_i & open_btn);
	wire       eff_close = (door_close_cmd_i | fire_close_q) & ~eff_open;
	wire [1:0] req = eff_open ? `DIR_OPEN : (eff_close ? `DIR_CLOSE : `DIR_NONE);
	wire [4:0] steps = timing_q[`TIM_STEP_MSB:`TIM_STEP_LSB];
	wire       ilk_on = (ctrl_q[`CTRL_LATCH_DOF] | ctrl_q[`CTRL_LATCH_DCF])
		&& steps != 5'h00;
	reg  [1:0] dir_q;
	reg        hold_q;
	reg  [9:0] hold_cnt_q;

	assign door_dir = dir_q;
	assign door_open_o = (dir_q == `DIR_OPEN);
	assign door_close_o = (dir_q == `DIR_CLOSE);

	always @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			dir_q      <= `DIR_NONE;
			hold_q     <= 1'b0;
			hold_cnt_q <= 10'h000;
		end else if (hold_q) begin
			if (ms_tick_q) begin
				if (hold_cnt_q <= 10'h001)
					hold_q <= 1'b0;
				hold_cnt_q <= hold_cnt_q - 10'h001;
			end
		end else if (dir_q != `DIR_NONE && req != `DIR_NONE && req != dir_q && ilk_on) begin
			dir_q      <= `DIR_NONE;
			hold_q     <= 1'b1;
			// steps above the top setting are held at the top
			hold_cnt_q <= (steps > `STEP_MAX ? {5'h00, `STEP_MAX} : {5'h00, steps})
				* {4'h0, `STEP_MS};
		end else begin
			dir_q <= req;
		end
	end

	// ********************************
	// lanterns and gongs
	// ********************************
	reg        slow_q;
	reg        lock_q;
	reg        down_q;
	reg        armed_q;
	reg [1:0]  strikes_q;
	reg        gap_q;
	reg [9:0]  strike_cnt_q;
	reg [9:0]  pass_cnt_q;
	reg [9:0]  egr_cnt_q;
	wire       slow_rise = car_slowing_i & ~slow_q;
	wire       lock_rise = door_lock_open_i & ~lock_q;
	wire       arrive = ctrl_q[`CTRL_HALL] ? slow_rise : lock_rise;
	wire       pass_ok = ~ctrl_q[`CTRL_PASS_BTN] | armed_q;
	wire       egr_hit = egress_q[`EGR_EN] && floor_i == egress_q[7:0];

	always @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			slow_q                 <= 1'b0;
			lock_q                 <= 1'b0;
			down_q                 <= 1'b0;
			armed_q                <= 1'b0;
			strikes_q              <= 2'h0;
			gap_q                  <= 1'b0;
			strike_cnt_q           <= 10'h000;
			lantern_o              <= 1'b0;
			gong_o                 <= 1'b0;
			pass_cnt_q             <= 10'h000;
			passing_floor_chime_o  <= 1'b0;
			egr_cnt_q              <= 10'h000;
			egress_arrival_chime_o <= 1'b0;
		end else begin
			slow_q <= car_slowing_i;
			lock_q <= door_lock_open_i;
			down_q <= dir_down_i;
			// a press in the same cycle as a reversal still arms
			if (passing_chime_enable_input_i)
				armed_q <= 1'b1;
			else if (dir_down_i != down_q)
				armed_q <= 1'b0;
			if (arrive) begin
				strikes_q    <= (ctrl_q[`CTRL_DBL] && dir_down_i) ? 2'h2 : 2'h1;
				gap_q        <= 1'b0;
				strike_cnt_q <= `STRIKE_MS;
				lantern_o    <= 1'b1;
				gong_o       <= 1'b1;
			end else if (strikes_q != 2'h0 && ms_tick_q) begin
				if (strike_cnt_q == 10'h001) begin
					strike_cnt_q <= `STRIKE_MS;
					if (gap_q) begin
						gap_q     <= 1'b0;
						lantern_o <= 1'b1;
						gong_o    <= 1'b1;
					end else begin
						strikes_q <= strikes_q - 2'h1;
						lantern_o <= 1'b0;
						gong_o    <= 1'b0;
						gap_q     <= (strikes_q == 2'h2);
					end
				end else begin
					strike_cnt_q <= strike_cnt_q - 10'h001;
				end
			end
			if (passing_floor_i && pass_ok) begin
				pass_cnt_q            <= `STRIKE_MS;
				passing_floor_chime_o <= 1'b1;
			end else if (passing_floor_chime_o && ms_tick_q) begin
				pass_cnt_q <= pass_cnt_q - 10'h001;
				if (pass_cnt_q == 10'h001)
					passing_floor_chime_o <= 1'b0;
			end
			if (lock_rise && egr_hit) begin
				egr_cnt_q              <= `STRIKE_MS;
				egress_arrival_chime_o <= 1'b1;
			end else if (egress_arrival_chime_o && ms_tick_q) begin
				egr_cnt_q <= egr_cnt_q - 10'h001;
				if (egr_cnt_q == 10'h001)
					egress_arrival_chime_o <= 1'b0;
			end
		end
	end

	// ********************************
	// car lantern
	// ********************************
	always @(posedge ref_clk_i) begin
		if (!rst_n_i)
			car_lantern_o <= 1'b0;
		else if (ctrl_q[`CTRL_FULL_OPEN]) begin
			// closing wins: the open limit is still made as the doors start to close
			if (door_closing_i)
				car_lantern_o <= 1'b0;
			else if (door_full_open_i)
				car_lantern_o <= 1'b1;
		end else begin
			if (door_opening_i)
				car_lantern_o <= 1'b1;
			else if (door_full_closed_i)
				car_lantern_o <= 1'b0;
		end
	end

	// ********************************
	// relay coil redundancy
	// ********************************
	wire mismatch = (monitored_relay_coil_i == relay_coil_readback_i);

	always @(posedge ref_clk_i) begin
		if (!rst_n_i)
			shutdown_o <= 1'b0;
		else if (mismatch)
			shutdown_o <= 1'b1;
		else if (auxiliary_fault_reset_i)
			shutdown_o <= 1'b0;
	end

	// ********************************
	// alarm bell warnings
	// ********************************
	reg       bell_q;
	reg [2:0] press_cnt_q;
	reg [6:0] win_cnt_q;
	reg [9:0] idle_cnt_q;
	reg [6:0] chk_cnt_q;
	reg       alarm_q;
	wire      press = alarm_bell_input_i & ~bell_q;
	wire      ev_zone = press & ~car_moving_i & ~door_zone_i;
	wire      ev_press = press && !car_moving_i
		&& press_cnt_q == `ALARM_PRESSES - 3'h1;
	wire      ev_idle = idle_check_req_o && sec_tick
		&& chk_cnt_q == `CHECK_S - 7'h01;
	wire      ev_any = ev_zone | ev_press | ev_idle;

	assign ev = {ev_idle, ev_press, ev_zone, mismatch & ~shutdown_o};

	always @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			bell_q            <= 1'b0;
			press_cnt_q       <= 3'h0;
			win_cnt_q         <= 7'h00;
			idle_cnt_q        <= 10'h000;
			chk_cnt_q         <= 7'h00;
			idle_check_req_o  <= 1'b0;
			alarm_q           <= 1'b0;
			monitor_alert_o   <= 1'b0;
			alarm_indicator_o <= 1'b0;
		end else begin
			bell_q <= alarm_bell_input_i;
			// movement ends the press window
			if (car_moving_i || ev_press) begin
				press_cnt_q <= 3'h0;
				win_cnt_q   <= 7'h00;
			end else if (press) begin
				press_cnt_q <= press_cnt_q + 3'h1;
			end else if (press_cnt_q != 3'h0 && sec_tick) begin
				if (win_cnt_q == `ALARM_WIN_S - 7'h01) begin
					press_cnt_q <= 3'h0;
					win_cnt_q   <= 7'h00;
				end else begin
					win_cnt_q <= win_cnt_q + 7'h01;
				end
			end
			if (car_moving_i || !door_zone_i || idle_movement_check_i) begin
				idle_cnt_q       <= 10'h000;
				chk_cnt_q        <= 7'h00;
				idle_check_req_o <= 1'b0;
			end else if (sec_tick) begin
				if (!idle_check_req_o) begin
					if (idle_cnt_q == `IDLE_S - 10'h001)
						idle_check_req_o <= 1'b1;
					idle_cnt_q <= idle_cnt_q + 10'h001;
				end else if (ev_idle) begin
					idle_cnt_q       <= 10'h000;
					chk_cnt_q        <= 7'h00;
					idle_check_req_o <= 1'b0;
				end else begin
					chk_cnt_q <= chk_cnt_q + 7'h01;
				end
			end
			// a new warning wins over the acknowledge
			if (ev_any)
				alarm_q <= 1'b1;
			else if (alarm_reset_ack_i)
				alarm_q <= 1'b0;
			monitor_alert_o   <= alarm_q | ev_any;
			alarm_indicator_o <= (alarm_q | ev_any) & ~alarm_reset_ack_i;
		end
	end

endmodule

`default_nettype wire

// ==== rtl/door_lantern_alarm_supervisor_defines.vh ====
/*
 * constants for the car door, lantern and alarm supervisor.
 * assumes a 25 MHz system clock and byte addressing on a 32-bit avalon-mm bus.
 */
`ifndef DOOR_LANTERN_ALARM_SUPERVISOR_DEFINES_VH
`define DOOR_LANTERN_ALARM_SUPERVISOR_DEFINES_VH

// ********************************
// timing
// ********************************
`define CLK_PERIOD_NS    40
`define MS_NS            1000000
`define MS_PER_S         10'h3e8
`define STEP_MS          6'h32
`define STEP_MAX         5'h13
`define RECLOSE_MAX_S    7'h78
`define STRIKE_MS        10'h0c8
`define ALARM_WIN_S      7'h3c
`define ALARM_PRESSES    3'h4
`define IDLE_S           10'h258
`define CHECK_S          7'h1e

// ********************************
// register map, byte offsets
// ********************************
`define ADDR_W           6
`define OFF_CTRL         6'h00
`define OFF_TIMING       6'h04
`define OFF_EGRESS       6'h08
`define OFF_STATE        6'h0c
`define OFF_INT_STAT     6'h10
`define OFF_INT_MASK     6'h14

// ctrl fields
`define CTRL_HALL        0
`define CTRL_DBL         1
`define CTRL_PASS_BTN    2
`define CTRL_FULL_OPEN   3
`define CTRL_LATCH_DOF   4
`define CTRL_LATCH_DCF   5
`define CTRL_W           6
`define CTRL_RST         6'h00

// timing fields: interlock steps [4:0], reclose seconds [14:8]
`define TIM_STEP_LSB     0
`define TIM_STEP_MSB     4
`define TIM_RECL_LSB     8
`define TIM_RECL_MSB     14

// egress: floor [7:0], enable [8]
`define EGR_EN           8

// interrupt bits
`define INT_W            4
`define INT_FAULT        0
`define INT_ALM_ZONE     1
`define INT_ALM_PRESS    2
`define INT_ALM_IDLE     3

// door drive codes
`define DIR_NONE         2'h0
`define DIR_OPEN         2'h1
`define DIR_CLOSE        2'h2

`endif

// ==== dv/supervisor_chk.sv ====
/*
 * port checker for the door, lantern and alarm supervisor.
 * assumes it is bound to the supervisor and sees only its ports.
 */
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// checker
// ****************************************
module supervisor_chk #(
	parameter MS_CYCLES = 25000
) (
	input wire logic ref_clk_i,
	input wire logic rst_n_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic avs_waitrequest_o,
	input wire logic door_open_cmd_i,
	input wire logic door_close_cmd_i,
	input wire logic door_open_o,
	input wire logic door_close_o,
	input wire logic monitored_relay_coil_i,
	input wire logic relay_coil_readback_i,
	input wire logic auxiliary_fault_reset_i,
	input wire logic shutdown_o,
	input wire logic alarm_bell_input_i,
	input wire logic alarm_reset_ack_i,
	input wire logic car_moving_i,
	input wire logic door_zone_i,
	input wire logic monitor_alert_o,
	input wire logic alarm_indicator_o,
	input wire logic lantern_o,
	input wire logic gong_o,
	input wire logic egress_arrival_chime_o,
	input wire logic door_lock_open_i,
	input wire logic door_full_closed_i,
	input wire logic car_lantern_o
);
	default clocking cb @(posedge ref_clk_i);
	endclocking
	default disable iff (!rst_n_i);

	a_fault_shutdown: assert property (
		monitored_relay_coil_i == relay_coil_readback_i |=> shutdown_o)
		else $error("relay mismatch without shutdown");
	a_fault_hold: assert property (
		shutdown_o && !auxiliary_fault_reset_i |=> shutdown_o)
		else $error("shutdown dropped without reset");
	a_aux_clear: assert property (
		(auxiliary_fault_reset_i && monitored_relay_coil_i != relay_coil_readback_i) [*2]
		|-> !shutdown_o)
		else $error("aux reset left shutdown");
	a_alarm_zone: assert property (
		$rose(alarm_bell_input_i) && !car_moving_i && !door_zone_i && !alarm_reset_ack_i
		|=> monitor_alert_o)
		else $error("no alert on press outside zone");
	a_indicator_blank: assert property (
		alarm_reset_ack_i [*2] |-> !alarm_indicator_o)
		else $error("indicator lit during ack");
	a_reverse_gap: assert property (
		door_open_o && !door_open_cmd_i && door_close_cmd_i |=> !door_open_o)
		else $error("open drive kept on reversal");
	a_door_exclusive: assert property (
		!(door_open_o && door_close_o))
		else $error("both door directions driven");
	a_lantern_gong: assert property (
		lantern_o == gong_o)
		else $error("lantern and gong differ");
	a_egress_lock: assert property (
		$rose(egress_arrival_chime_o) |-> door_lock_open_i)
		else $error("egress chime with lock shut");
	a_closed_dark: assert property (
		door_full_closed_i [*2] |-> !car_lantern_o)
		else $error("car lantern on with doors closed");
	a_bus_answer: assert property (
		(avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o)
		else $error("bus wait longer than one cycle");

	cover property ($rose(shutdown_o));
	cover property ($rose(monitor_alert_o));
	cover property ($rose(car_lantern_o));
endmodule

bind door_lantern_alarm_supervisor supervisor_chk #(.MS_CYCLES(MS_CYCLES)) supervisor_chk_inst (.*);
`default_nettype wire

// ==== dv/door_fixture_model.sv ====
/*
 * far side: door operator with an eight-step travel and the relay readback.
 * assumes the drive levels come from the supervisor on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// door operator and relay
// ****************************************
module door_fixture_model (
	input  wire logic clk_i,
	input  wire logic open_i,
	input  wire logic close_i,
	input  wire logic coil_i,
	input  wire logic fault_i,
	output logic      opening_o,
	output logic      closing_o,
	output logic      full_open_o,
	output logic      full_closed_o,
	output logic      readback_o
);
	logic [3:0] pos_q = 4'h0;

	always @(posedge clk_i) begin
		if (open_i && pos_q != 4'h8) begin
			pos_q <= pos_q + 4'h1;
		end else if (close_i && pos_q != 4'h0) begin
			pos_q <= pos_q - 4'h1;
		end
	end
	assign opening_o     = open_i && pos_q != 4'h8;
	assign closing_o     = close_i && pos_q != 4'h0;
	assign full_open_o   = pos_q == 4'h8;
	assign full_closed_o = pos_q == 4'h0;
	// healthy relay reads back inverted; fault_i breaks it on purpose
	assign readback_o    = ~coil_i ^ fault_i;
endmodule
`default_nettype wire

// ==== dv/tb_door_lantern_alarm_supervisor.sv ====
/*
 * self-checking bench for the door, lantern and alarm supervisor.
 * assumes a 10-cycle millisecond tick to keep the long timers short.
 */
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// bench
// ****************************************
module tb_door_lantern_alarm_supervisor;
	localparam int MS = 10;
	logic ref_clk_i = 1'b0, rst_n_i = 1'b0, avs_read_i = 1'b0, avs_write_i = 1'b0;
	logic [5:0] avs_address_i = 6'h00;
	logic [31:0] avs_writedata_i = 32'h0, avs_readdata_o, q;
	logic avs_waitrequest_o, irq_o, door_open_o, door_close_o, idle_check_req_o, lantern_o;
	logic gong_o, passing_floor_chime_o, egress_arrival_chime_o, car_lantern_o, shutdown_o;
	logic monitor_alert_o, alarm_indicator_o, door_opening_i, door_closing_i;
	logic door_full_open_i, door_full_closed_i, relay_coil_readback_i, fault;
	logic door_open_cmd_i = 1'b0, door_close_cmd_i = 1'b0, fire_recall_i = 1'b0;
	logic car_door_open_btn_i = 1'b0, hall_door_open_btn_i = 1'b0, car_slowing_i = 1'b0;
	logic door_lock_open_i = 1'b0, dir_down_i = 1'b0, passing_floor_i = 1'b0;
	logic passing_chime_enable_input_i = 1'b0, monitored_relay_coil_i = 1'b1;
	logic auxiliary_fault_reset_i = 1'b0, alarm_bell_input_i = 1'b0, alarm_reset_ack_i = 1'b0;
	logic car_moving_i = 1'b0, door_zone_i = 1'b0, idle_movement_check_i = 1'b0;
	logic [7:0] floor_i = 8'h00;
	int n_mismatch = 0;
	int comparisons = 0;
	int n;

	initial fault = 1'b0;
	initial forever #20 ref_clk_i = ~ref_clk_i;

	door_lantern_alarm_supervisor #(.MS_CYCLES(MS)) door_lantern_alarm_supervisor_inst (.*);
	door_fixture_model door_fixture_model_inst (.clk_i(ref_clk_i), .open_i(door_open_o),
		.close_i(door_close_o), .coil_i(monitored_relay_coil_i), .fault_i(fault),
		.opening_o(door_opening_i), .closing_o(door_closing_i),
		.full_open_o(door_full_open_i), .full_closed_o(door_full_closed_i),
		.readback_o(relay_coil_readback_i));

	task automatic test_done;
		$display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
		if (n_mismatch == 0 && comparisons > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		comparisons++;
		if (got !== exp) begin
			n_mismatch++;
			$display("ERROR %0t %s got %h expected %h", $time, what, got, exp);
		end
	endtask
	task automatic hang(input int lim);
		if (n >= lim) begin
			chk(0, 1, "wait timed out");
			test_done();
		end
	endtask
	task automatic tick(input int c);
		repeat (c) @(posedge ref_clk_i);
	endtask
	// one access; request held until waitrequest is seen low at an edge
	task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
		avs_address_i <= a;
		avs_writedata_i <= d;
		avs_write_i <= wr;
		avs_read_i <= !wr;
		n = 0;
		do begin
			@(posedge ref_clk_i);
			n++;
		end while (avs_waitrequest_o !== 1'b0 && n < 20);
		hang(20);
		q = avs_readdata_o;
		avs_write_i <= 1'b0;
		avs_read_i <= 1'b0;
		tick(1);
	endtask
	task automatic s_regs;
		bus(0, 6'h00, 0);
		chk(q, 32'h0, "ctrl reset");
		bus(1, 6'h00, 32'h3f);
		bus(0, 6'h00, 0);
		chk(q, 32'h3f, "ctrl rw");
		bus(1, 6'h3c, 32'hff);
		bus(0, 6'h3c, 0);
		chk(q, 32'h0, "unmapped");
		bus(1, 6'h00, 0);
	endtask
	task automatic s_interlock;
		bus(1, 6'h00, 32'h10);
		bus(1, 6'h04, 32'h02);
		door_open_cmd_i <= 1'b1;
		tick(3);
		chk(door_open_o, 1, "open drive");
		door_open_cmd_i <= 1'b0;
		door_close_cmd_i <= 1'b1;
		tick(2);
		chk({door_open_o, door_close_o}, 0, "interlock idle");
		for (n = 0; n < 110 * MS && !door_close_o; n++) tick(1);
		hang(110 * MS);
		chk(n >= 97 * MS, 1, "interlock length");
		bus(1, 6'h00, 32'h00);
		door_close_cmd_i <= 1'b0;
		door_open_cmd_i <= 1'b1;
		tick(2);
		chk(door_open_o, 1, "no interlock without latch");
		door_open_cmd_i <= 1'b0;
	endtask
	task automatic s_reclose;
		bus(1, 6'h04, 32'h100);
		fire_recall_i <= 1'b1;
		for (n = 0; n < 1002 * MS && !door_close_o; n++) tick(1);
		hang(1002 * MS);
		car_door_open_btn_i <= 1'b1;
		tick(3);
		chk(door_open_o, 1, "car button reopens");
		car_door_open_btn_i <= 1'b0;
		for (n = 0; n < 2004 * MS && !door_close_o; n++) tick(1);
		hang(2004 * MS);
		hall_door_open_btn_i <= 1'b1;
		tick(3);
		chk(door_open_o, 1, "hall button reopens");
		hall_door_open_btn_i <= 1'b0;
		fire_recall_i <= 1'b0;
		bus(1, 6'h04, 0);
	endtask
	task automatic s_fault;
		bus(1, 6'h14, 32'h1);
		fault <= 1'b1;
		tick(3);
		chk({shutdown_o, irq_o}, 3, "fault shutdown and irq");
		fault <= 1'b0;
		bus(0, 6'h10, 0);
		chk(q, 32'h1, "fault status");
		bus(1, 6'h10, 32'h1);
		chk({shutdown_o, irq_o}, 2, "irq cleared, fault latched");
		auxiliary_fault_reset_i <= 1'b1;
		tick(3);
		auxiliary_fault_reset_i <= 1'b0;
		chk(shutdown_o, 0, "aux reset");
	endtask
	task automatic press;
		alarm_bell_input_i <= 1'b1;
		tick(2);
		alarm_bell_input_i <= 1'b0;
		tick(2);
	endtask
	task automatic s_alarm;
		press();
		chk({monitor_alert_o, alarm_indicator_o}, 3, "alarm outside zone");
		alarm_reset_ack_i <= 1'b1;
		car_moving_i <= 1'b1;
		tick(3);
		chk(alarm_indicator_o, 0, "indicator blanked");
		alarm_reset_ack_i <= 1'b0;
		car_moving_i <= 1'b0;
		door_zone_i <= 1'b1;
		tick(2);
		chk(monitor_alert_o, 0, "ack clears alarm");
		repeat (3) press();
		chk(monitor_alert_o, 0, "three presses");
		press();
		chk(monitor_alert_o, 1, "fourth press");
		alarm_reset_ack_i <= 1'b1;
		tick(3);
		alarm_reset_ack_i <= 1'b0;
	endtask
	// count lantern strikes after a slowdown or a lock opening
	task automatic s_lantern(input logic [31:0] ctl, input logic dn, lk, input int exp);
		int k;
		logic pl;
		bus(1, 6'h00, ctl);
		dir_down_i <= dn;
		tick(2);
		car_slowing_i <= 1'b1;
		door_lock_open_i <= lk;
		k = 0;
		pl = lantern_o;
		repeat (800 * MS) begin
			tick(1);
			if (lantern_o && !gong_o) k = k - 8;
			if (lantern_o && !pl) k++;
			pl = lantern_o;
		end
		chk(k, exp, "strike count");
		car_slowing_i <= 1'b0;
		door_lock_open_i <= 1'b0;
	endtask
	task automatic s_egress(input logic [31:0] cfg, input logic [7:0] f, input logic exp);
		bus(1, 6'h08, cfg);
		floor_i <= f;
		door_lock_open_i <= 1'b1;
		tick(3);
		chk(egress_arrival_chime_o, exp, "egress chime");
		door_lock_open_i <= 1'b0;
		tick(300 * MS);
	endtask
	// passing chime armed by a press, dropped when the direction flips
	task automatic s_passing;
		bus(1, 6'h00, 32'h4);
		passing_floor_i <= 1'b1;
		tick(1);
		passing_floor_i <= 1'b0;
		tick(2);
		chk(passing_floor_chime_o, 0, "chime before press");
		passing_chime_enable_input_i <= 1'b1;
		tick(1);
		passing_chime_enable_input_i <= 1'b0;
		passing_floor_i <= 1'b1;
		tick(1);
		passing_floor_i <= 1'b0;
		tick(2);
		chk(passing_floor_chime_o, 1, "chime after press");
		tick(300 * MS);
		dir_down_i <= !dir_down_i;
		tick(2);
		passing_floor_i <= 1'b1;
		tick(1);
		passing_floor_i <= 1'b0;
		tick(2);
		chk(passing_floor_chime_o, 0, "chime after reversal");
	endtask
	task automatic s_car_lantern(input logic full);
		bus(1, 6'h00, {28'h0, full, 3'h0});
		door_open_cmd_i <= 1'b1;
		tick(3);
		chk(car_lantern_o, !full, "lantern while opening");
		tick(12);
		chk(car_lantern_o, 1, "lantern at full open");
		door_open_cmd_i <= 1'b0;
		door_close_cmd_i <= 1'b1;
		tick(3);
		chk(car_lantern_o, !full, "lantern while closing");
		tick(12);
		chk(car_lantern_o, 0, "lantern when closed");
		door_close_cmd_i <= 1'b0;
	endtask

	initial begin
		tick(16);
		rst_n_i <= 1'b1;
		tick(1);
		s_regs();
		s_interlock();
		s_car_lantern(0);
		s_car_lantern(1);
		s_reclose();
		s_fault();
		s_alarm();
		s_lantern(32'h3, 1, 0, 2);
		s_lantern(32'h3, 0, 0, 1);
		s_lantern(32'h0, 0, 0, 0);
		s_lantern(32'h0, 0, 1, 1);
		s_egress(32'h105, 8'h05, 1);
		s_egress(32'h105, 8'h06, 0);
		s_egress(32'h005, 8'h05, 0);
		s_passing();
		test_done();
	end
endmodule
`default_nettype wire
